/* File: flash_self_program_ctrl_tb.sv */
// Self-checking bench for the flash self-programming controller.
`timescale 1ns/100ps
`default_nettype none
module flash_self_program_ctrl_tb;
	import fsp_pkg::*;
	localparam int IW = 8;
	logic           i_clk, i_sys_rst, i_por_rst, i_wr, i_rd, o_stall, rd_d;
	logic [2:0]     i_addr;
	logic [7:0]     i_wdata, o_rdata, d;
	logic [20:0]    o_fl_rd_word;
	logic [15:0]    i_fl_rdata;
	logic [21:0]    ptr, p;
	logic [511:0]   o_hold_bytes, hold_exp;
	fsp_table_req_t i_tbl;
	fsp_array_cmd_t o_fl_cmd, cmd_seen;
	logic [7:0]     exp_q[$];
	int             err_total, n_compared, n_stall;

	fsp_ctrl #(.IW_CYCLES(IW)) u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_por_rst(i_por_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tbl(i_tbl),
		.o_fl_rd_word(o_fl_rd_word), .i_fl_rdata(i_fl_rdata),
		.o_fl_cmd(o_fl_cmd), .o_hold_bytes(o_hold_bytes), .o_stall(o_stall));
	fsp_array_model u_flash (.i_word(o_fl_rd_word), .o_data(i_fl_rdata));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic check(input string nm, input logic [511:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Read data stand from the cycle after the strobe until the next read strobe.
	always @(posedge i_clk) begin
		rd_d <= i_rd;
		if (rd_d === 1'b1 && exp_q.size() > 0)
			check("o_rdata", 512'(o_rdata), 512'(exp_q.pop_front()));
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_q.push_back(v);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask

	task automatic tbl(input logic r, input fsp_ptr_mode_t m);
		@(posedge i_clk);
		i_tbl <= '{rd: r, wr: !r, mode: m};
		@(posedge i_clk);
		i_tbl <= '0;
	endtask

	task automatic set_ptr(input logic [21:0] v);
		wr(FSP_OFS_PTR_L, v[7:0]);
		wr(FSP_OFS_PTR_H, v[15:8]);
		wr(FSP_OFS_PTR_U, {2'b00, v[21:16]});
		ptr = v;
	endtask

	// Unlock, start, then count stalled cycles; cut pulses reset mid-write.
	task automatic launch(input logic [7:0] pre, go, input int cut);
		wr(FSP_OFS_CTRL, pre);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= FSP_OFS_UNLOCK;
		i_wdata <= FSP_KEY1;
		@(posedge i_clk);
		i_wdata <= FSP_KEY2;
		@(posedge i_clk);
		i_addr <= FSP_OFS_CTRL;
		i_wdata <= go;
		@(posedge i_clk);
		i_wr <= 1'b0;
		n_stall = 0;
		cmd_seen = '0;
		for (int i = 0; i < 40; i++) begin
			#1;
			if (o_stall === 1'b1 && n_stall == 0)
				cmd_seen = o_fl_cmd;
			if (o_stall === 1'b1)
				n_stall++;
			@(posedge i_clk);
			i_sys_rst <= (i == cut);
		end
	endtask

	function automatic logic [7:0] fbyte(input logic [21:0] a);
		return a[0] ? (a[8:1] ^ 8'h5A) : (a[8:1] + 8'h01);
	endfunction

	initial begin
		{i_wr, i_rd, rd_d, i_addr, i_wdata} = '0;
		i_tbl = '0;
		i_sys_rst = 1'b1;
		i_por_rst = 1'b1;
		hold_exp = '0;
		void'($urandom(32'h0062));
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		i_por_rst <= 1'b0;
		rd(FSP_OFS_CTRL, 8'h00);
		rd(FSP_OFS_UNLOCK, 8'h00);
		$display("test reset done");
		set_ptr({1'b0, 21'($urandom) & 21'h1F_FFFE});
		for (int m = 0; m < 4; m++) begin
			tbl(1'b1, fsp_ptr_mode_t'(m));
			p = (m == 3) ? ptr + 22'h00_0001 : ptr;
			rd(FSP_OFS_LATCH, fbyte(p));
			ptr = (m == 2) ? ptr - 22'h00_0001 : ((m == 0) ? ptr : p + 22'(m == 1));
			rd(FSP_OFS_PTR_L, ptr[7:0]);
		end
		$display("test table read done");
		p = 22'($urandom);
		set_ptr(p);
		launch(8'h14, 8'h16, -1);
		check("stall", 512'(n_stall), 512'(IW + 1));
		check("erase", 512'(cmd_seen), 512'({3'b100, p[21:10], 10'h000}));
		check("idle cmd", 512'(o_fl_cmd), 512'(0));
		rd(FSP_OFS_CTRL, 8'h04);
		launch(8'h10, 8'h12, -1);
		check("no write_enable_bit", 512'(n_stall), 512'(0));
		wr(FSP_OFS_CTRL, 8'h04);
		wr(FSP_OFS_UNLOCK, FSP_KEY1);
		wr(FSP_OFS_LATCH, 8'h00);
		wr(FSP_OFS_UNLOCK, FSP_KEY2);
		wr(FSP_OFS_CTRL, 8'h06);
		repeat (3) @(posedge i_clk);
		check("broken unlock", 512'(o_stall), 512'(0));
		rd(FSP_OFS_CTRL, 8'h04);
		$display("test erase and refusals done");
		p = {1'b0, 15'($urandom) | 15'h0001, 6'h00};
		set_ptr(p - 22'h00_0001);
		for (int i = 0; i < 64; i++) begin
			d = 8'($urandom);
			hold_exp[8*i+:8] = d;
			wr(FSP_OFS_LATCH, d);
			tbl(1'b0, FSP_PTR_PRE_INC);
		end
		#1;
		check("hold", o_hold_bytes, hold_exp);
		check("short write", 512'(o_fl_cmd), 512'(0));
		launch(8'h04, 8'h06, -1);
		check("stall", 512'(n_stall), 512'(IW + 1));
		check("block", 512'(cmd_seen), 512'({3'b010, p}));
		check("hold kept", o_hold_bytes, hold_exp);
		$display("test block program done");
		p = {1'b0, 21'($urandom) & 21'h1F_FFFE};
		set_ptr(p);
		for (int i = 0; i < 2; i++) begin
			d = 8'($urandom);
			hold_exp[8*(p[5:0]+i)+:8] = d;
			wr(FSP_OFS_LATCH, d);
			tbl(1'b0, (i == 0) ? FSP_PTR_POST_INC : FSP_PTR_KEEP);
		end
		launch(8'h24, 8'h26, -1);
		check("word", 512'(cmd_seen), 512'({3'b011, p}));
		check("hold word", o_hold_bytes, hold_exp);
		rd(FSP_OFS_CTRL, 8'h24);
		$display("test word program done");
		launch(8'h14, 8'h16, 3);
		check("stall cut", 512'(o_stall), 512'(0));
		rd(FSP_OFS_CTRL, 8'h08);
		$display("test reset mid write done");
		repeat (3) @(posedge i_clk);
		complete_run();
	end
endmodule
`default_nettype wire

/* File: fsp_array_model.sv */
// Flash array stand-in that answers each word address with a fixed pattern.
`timescale 1ns/100ps
`default_nettype none
module fsp_array_model (
	// Word read port.
	input  wire logic [20:0] i_word,
	output logic      [15:0] o_data
);
	// The word is a function of its address, so the bench can predict it.
	assign o_data = {i_word[7:0] ^ 8'h5A, i_word[7:0] + 8'h01};
endmodule
`default_nettype wire

/* File: fsp_ctrl.sv */
// Flash self-programming controller: table ops, unlock, timed erase/program.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl import fsp_pkg::*; #(
	parameter int IW_CYCLES = FSP_IW_CYCLES
) (
	// Clock and resets.
	input  wire logic                 i_clk,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_por_rst,
	// Register port.
	input  wire logic [2:0]           i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic [7:0]                o_rdata,
	// Table operations from the core.
	input  wire fsp_table_req_t       i_tbl,
	// Flash array.
	output logic [20:0]               o_fl_rd_word,
	input  wire logic [15:0]          i_fl_rdata,
	output fsp_array_cmd_t            o_fl_cmd,
	output logic [8*FSP_HOLD_N-1:0]   o_hold_bytes,
	// Core stall.
	output logic                      o_stall
);

	fsp_state_t     state_r;
	logic [31:0]    cnt_r;
	logic [21:0]    ptr_r;
	logic [21:0]    ptr_nxt;
	logic [21:0]    eff_addr;
	logic [7:0]     latch_r;
	logic [7:0]     hold_r [FSP_HOLD_N];
	logic           word_sel_r;
	logic           free_r;
	logic           wr_en_r;
	logic           abort_r;
	logic           key1_r;
	logic           armed_r;
	logic [7:0]     rdata_r;
	fsp_array_cmd_t cmd_r;
	logic           idle;
	logic           reg_wr;
	logic           ctrl_wr;
	logic           unlock_wr;
	logic           start;
	logic           finish;
	logic           tbl_rd;
	logic           tbl_wr;

	assign idle      = (state_r == FSP_ST_IDLE);
	// Register writes are dropped while the core is stalled.
	assign reg_wr    = i_wr && idle;
	assign ctrl_wr   = reg_wr && (i_addr == FSP_OFS_CTRL);
	assign unlock_wr = reg_wr && (i_addr == FSP_OFS_UNLOCK);
	assign tbl_rd    = i_tbl.rd && idle;
	assign tbl_wr    = i_tbl.wr && idle;
	// Start needs the armed key pair and write enable.
	assign start     = ctrl_wr && i_wdata[FSP_BIT_WR] && armed_r && wr_en_r;
	assign finish    = (state_r == FSP_ST_BUSY) &&
		(cnt_r == 32'(IW_CYCLES - 1));

	// Effective address: pre-increment moves before the access; only the
	// low 21 bits ever move.
	always_comb begin
		eff_addr = ptr_r;
		ptr_nxt  = ptr_r;
		unique case (i_tbl.mode)
			FSP_PTR_KEEP: begin
				ptr_nxt = ptr_r;
			end
			FSP_PTR_POST_INC: begin
				ptr_nxt = {ptr_r[21], ptr_r[20:0] + 21'h1};
			end
			FSP_PTR_POST_DEC: begin
				ptr_nxt = {ptr_r[21], ptr_r[20:0] - 21'h1};
			end
			FSP_PTR_PRE_INC: begin
				eff_addr = {ptr_r[21], ptr_r[20:0] + 21'h1};
				ptr_nxt  = eff_addr;
			end
		endcase
	end

	assign o_fl_rd_word = eff_addr[21:1];

	// Table pointer.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ptr_r <= FSP_PTR_RST;
		end else if (tbl_rd || tbl_wr) begin
			ptr_r <= ptr_nxt;
		end else if (reg_wr && i_addr == FSP_OFS_PTR_L) begin
			ptr_r[7:0] <= i_wdata;
		end else if (reg_wr && i_addr == FSP_OFS_PTR_H) begin
			ptr_r[15:8] <= i_wdata;
		end else if (reg_wr && i_addr == FSP_OFS_PTR_U) begin
			ptr_r[21:16] <= i_wdata[5:0];
		end
	end

	// Table latch: one byte per read, odd address is the high byte.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			latch_r <= FSP_LATCH_RST;
		end else if (tbl_rd) begin
			latch_r <= eff_addr[0] ? i_fl_rdata[15:8] : i_fl_rdata[7:0];
		end else if (reg_wr && i_addr == FSP_OFS_LATCH) begin
			latch_r <= i_wdata;
		end
	end

	// Holding registers: short writes only, kept across program cycles.
	genvar gi;
	generate
		for (gi = 0; gi < FSP_HOLD_N; gi++) begin : g_hold
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					hold_r[gi] <= FSP_LATCH_RST;
				end else if (tbl_wr &&
					eff_addr[FSP_BLOCK_LSB-1:0] == 6'(gi)) begin
					hold_r[gi] <= latch_r;
				end
			end
			assign o_hold_bytes[8*gi +: 8] = hold_r[gi];
		end
	endgenerate

	// Unlock sequence: the two keys must be back-to-back register writes.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			key1_r  <= 1'b0;
			armed_r <= 1'b0;
		end else if (reg_wr) begin
			key1_r  <= unlock_wr && (i_wdata == FSP_KEY1);
			armed_r <= unlock_wr && (i_wdata == FSP_KEY2) && key1_r;
		end
	end

	// Control bits.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			word_sel_r <= 1'b0;
			free_r     <= 1'b0;
			wr_en_r    <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				word_sel_r <= i_wdata[FSP_BIT_WORD_SEL];
				wr_en_r    <= i_wdata[FSP_BIT_WR_EN];
			end
			if (finish && cmd_r.erase) begin
				free_r <= 1'b0;
			end else if (ctrl_wr) begin
				free_r <= i_wdata[FSP_BIT_FREE];
			end
		end
	end

	// Abort flag survives the system reset so an interrupted write shows.
	always_ff @(posedge i_clk) begin
		if (i_por_rst) begin
			abort_r <= 1'b0;
		end else if (start) begin
			abort_r <= 1'b1;
		end else if (finish) begin
			abort_r <= 1'b0;
		end else if (ctrl_wr) begin
			abort_r <= i_wdata[FSP_BIT_ABORT];
		end
	end

	// Long-write sequencer.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_r <= FSP_ST_IDLE;
			cnt_r   <= 32'h0000_0000;
		end else begin
			unique case (state_r)
				FSP_ST_IDLE: begin
					cnt_r <= 32'h0000_0000;
					if (start) begin
						state_r <= FSP_ST_BUSY;
					end
				end
				FSP_ST_BUSY: begin
					cnt_r <= cnt_r + 32'h0000_0001;
					if (finish) begin
						state_r <= FSP_ST_DONE;
					end
				end
				FSP_ST_DONE: begin
					state_r <= FSP_ST_IDLE;
				end
				default: begin
					state_r <= FSP_ST_IDLE;
				end
			endcase
		end
	end

	// Array command: erase a row, program a 64-byte block or one word. Only row
	// erase exists; no wider erase can be commanded from here.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cmd_r <= '0;
		end else if (start) begin
			cmd_r.erase <= free_r;
			cmd_r.prog  <= !free_r;
			cmd_r.word  <= !free_r && word_sel_r;
			if (free_r) begin
				cmd_r.addr <= {ptr_r[21:FSP_ROW_LSB], 10'h000};
			end else if (word_sel_r) begin
				cmd_r.addr <= {ptr_r[21:1], 1'b0};
			end else begin
				cmd_r.addr <= {ptr_r[21:FSP_BLOCK_LSB], 6'h00};
			end
		end else if (finish) begin
			cmd_r <= '0;
		end
	end

	assign o_fl_cmd = cmd_r;
	// The core is held from the cycle after the start write through the done cycle after the timer ends.
	assign o_stall  = !idle;

	// Read data, one cycle after the strobe; the unlock port reads zero.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_r <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				FSP_OFS_PTR_L: rdata_r <= ptr_r[7:0];
				FSP_OFS_PTR_H: rdata_r <= ptr_r[15:8];
				FSP_OFS_PTR_U: rdata_r <= {2'b00, ptr_r[21:16]};
				FSP_OFS_LATCH: rdata_r <= latch_r;
				FSP_OFS_CTRL:  rdata_r <= {2'b00, word_sel_r, free_r,
					abort_r, wr_en_r, !idle, 1'b0};
				default:       rdata_r <= 8'h00;
			endcase
		end
	end

	assign o_rdata = rdata_r;

	sequence s_unlock;
		unlock_wr && i_wdata == FSP_KEY1 ##1 unlock_wr && i_wdata == FSP_KEY2;
	endsequence

	sequence s_start_req;
		ctrl_wr && i_wdata[FSP_BIT_WR] && wr_en_r;
	endsequence

	sequence s_timer_out;
		finish ##1 state_r == FSP_ST_DONE;
	endsequence

	// Stall length in cycles; it restarts from zero whenever the core runs.
	logic [31:0] stall_len_r;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || idle) begin
			stall_len_r <= 32'h0000_0000;
		end else begin
			stall_len_r <= stall_len_r + 32'h0000_0001;
		end
	end

	chk_start_needs_unlock: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) (idle ##1 !idle) |-> $past(armed_r))
		else $error("long write started without unlock");

	chk_unlock_arms: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) s_unlock ##1 s_start_req |=> o_stall)
		else $error("unlock then start did not stall");

	chk_enable_gate: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) (idle && !wr_en_r) |=> idle)
		else $error("cycle started with write enable clear");

	chk_stall_length: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) state_r == FSP_ST_DONE |->
		stall_len_r == 32'(IW_CYCLES))
		else $error("stall length differs from the timer");

	chk_timer_end: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) finish |=> state_r == FSP_ST_DONE ##1 idle)
		else $error("timer end did not release");

	chk_abort_flag: assert property (@(posedge i_clk)
		disable iff (i_sys_rst || i_por_rst) start |=> abort_r throughout
		(state_r == FSP_ST_BUSY)[*1])
		else $error("abort flag not set at start");

	chk_abort_clear: assert property (@(posedge i_clk)
		disable iff (i_sys_rst || i_por_rst) s_timer_out |->
		!abort_r && o_fl_cmd == '0)
		else $error("abort flag or command left after timer end");

	chk_cmd_held: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) state_r == FSP_ST_BUSY |->
		o_stall && (o_fl_cmd.erase || o_fl_cmd.prog))
		else $error("array command dropped during long write");

	chk_single_row: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) o_fl_cmd.erase |->
		!o_fl_cmd.prog && o_fl_cmd.addr[9:0] == 10'h000)
		else $error("erase is not exactly one row");

	chk_hold_kept: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) (!idle && !i_sys_rst) |=>
		$stable(o_hold_bytes))
		else $error("holding registers changed by a long write");

	chk_short_write: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) (tbl_wr && !start && !i_sys_rst) |=>
		$stable(o_fl_cmd))
		else $error("table write touched the array command");

	chk_start_reads: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rd && i_addr == FSP_OFS_CTRL && !i_sys_rst) |=>
		o_rdata[FSP_BIT_WR] == !$past(idle))
		else $error("start bit does not follow the long write");

	chk_ptr_upper: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		((tbl_rd || tbl_wr) && !i_sys_rst) |=>
		ptr_r[21] == $past(ptr_r[21]))
		else $error("table op moved the top pointer bit");

	chk_block_align: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) (start && !free_r && !word_sel_r) |=>
		cmd_r.prog && !cmd_r.word && cmd_r.addr[5:0] == 6'h00)
		else $error("block program address not aligned");

	chk_row_addr: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) (start && free_r) |=>
		cmd_r.erase && cmd_r.addr[9:0] == 10'h000 &&
		cmd_r.addr[21:10] == $past(ptr_r[21:10]))
		else $error("row erase address wrong");

	chk_read_byte: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) tbl_rd |=> latch_r ==
		($past(eff_addr[0]) ? $past(i_fl_rdata[15:8]) :
		$past(i_fl_rdata[7:0])))
		else $error("table read byte lane wrong");

	chk_hold_write: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) tbl_wr |=>
		hold_r[$past(eff_addr[5:0])] == $past(latch_r))
		else $error("holding register not loaded");

	chk_word_mode: assert property (@(posedge i_clk)
		disable iff (i_sys_rst) (start && !free_r) |=>
		cmd_r.prog && cmd_r.word == $past(word_sel_r))
		else $error("program size select wrong");

endmodule
`default_nettype wire

/* File: fsp_ctrl_pkg_note.sv */
// This file holds no logic of the block.

/* File: fsp_pkg.sv */
// Constants and types for the flash self-programming controller.
// Contract
// - Each table read fetches one byte at the pointer into the latch, optional adjust.
// - Pointer bit 0 selects high or low byte of the 16-bit word.
// - Erase clears one whole 1024-byte row; no single-word erase.
// - Row erase uses pointer bits 21:10 and ignores bits 9:0.
// - Larger erases come only from external programming, never from self-programming.
// - Erase needs write enable, row-erase select and unlock before start.
// - Software writes 55h then 0AAh to unlock port, then sets start.
// - During a long write execution halts; internal timer ends the cycle.
// - Processor stalls for the full timed duration, then resumes.
// - Program 64 bytes per cycle, or one two-byte word.
// - Sixty-four byte-wide holding registers are loaded by table writes.
// - A table write only updates a holding register, never the array.
// - Holding registers keep their contents after a program cycle.
// - Word select set programs two bytes, clear programs 64 bytes.
// - Start bit is set by software only and cleared by hardware on completion.
// - Abort flag sets on start, clears on normal timer expiry only; here a control write also loads it from bit 3.
// - Table writes pick the holding register from the low pointer bits.
package fsp_pkg;

	// Register offsets on the 8-bit register port.
	localparam logic [2:0] FSP_OFS_PTR_L  = 3'h0;
	localparam logic [2:0] FSP_OFS_PTR_H  = 3'h1;
	localparam logic [2:0] FSP_OFS_PTR_U  = 3'h2;
	localparam logic [2:0] FSP_OFS_LATCH  = 3'h3;
	localparam logic [2:0] FSP_OFS_CTRL   = 3'h4;
	localparam logic [2:0] FSP_OFS_UNLOCK = 3'h5;

	// Control register bit positions.
	localparam int FSP_BIT_WORD_SEL = 5;
	localparam int FSP_BIT_FREE     = 4;
	localparam int FSP_BIT_ABORT    = 3;
	localparam int FSP_BIT_WR_EN    = 2;
	localparam int FSP_BIT_WR       = 1;

	// Unlock keys.
	localparam logic [7:0] FSP_KEY1 = 8'h55;
	localparam logic [7:0] FSP_KEY2 = 8'hAA;

	// Geometry.
	localparam int FSP_PTR_W     = 22;
	localparam int FSP_HOLD_N    = 64;
	localparam int FSP_ROW_LSB   = 10;
	localparam int FSP_BLOCK_LSB = 6;

	// Reset values.
	localparam logic [21:0] FSP_PTR_RST   = 22'h00_0000;
	localparam logic [7:0]  FSP_LATCH_RST = 8'h00;

	// Self-timed write duration.
	localparam int FSP_CLK_NS    = 100;
	localparam int FSP_T_IW_NS   = 1000000;
	localparam int FSP_IW_CYCLES = (FSP_T_IW_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;

	typedef enum logic [1:0] {
		FSP_PTR_KEEP = 2'h0,
		FSP_PTR_POST_INC = 2'h1,
		FSP_PTR_POST_DEC = 2'h2,
		FSP_PTR_PRE_INC = 2'h3
	} fsp_ptr_mode_t;

	typedef enum logic [1:0] {
		FSP_ST_IDLE = 2'b00,
		FSP_ST_BUSY = 2'b01,
		FSP_ST_DONE = 2'b11
	} fsp_state_t;

	// Command to the flash array, held for the whole long write.
	typedef struct packed {
		logic        erase;
		logic        prog;
		logic        word;
		logic [21:0] addr;
	} fsp_array_cmd_t;

	// Table operation request from the core.
	typedef struct packed {
		logic          rd;
		logic          wr;
		fsp_ptr_mode_t mode;
	} fsp_table_req_t;

endpackage
